// ### cct_pkg.sv
package cct_pkg;

  // ==========================================================================
  // Register addresses on the 8-bit CPU bus.
  localparam logic [15:0] ADDR_CTRL = 16'hFF90;
  localparam logic [15:0] ADDR_FLAGS = 16'hFF91;
  localparam logic [15:0] ADDR_CNT_HI = 16'hFF92;
  localparam logic [15:0] ADDR_CNT_LO = 16'hFF93;
  localparam logic [15:0] ADDR_CMPA_HI = 16'hFF94;
  localparam logic [15:0] ADDR_CMPA_LO = 16'hFF95;
  localparam logic [15:0] ADDR_CMPB_HI = 16'hFF96;
  localparam logic [15:0] ADDR_CMPB_LO = 16'hFF97;
  localparam logic [15:0] ADDR_CAP_HI = 16'hFF98;
  localparam logic [15:0] ADDR_CAP_LO = 16'hFF99;

  // ==========================================================================
  // Values after reset and standby, and the count maximum.
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;

  // ==========================================================================
  // Flag and level register fields. Flag index 3..0 sits at bits 7..4.
  localparam int FLAG_BASE = 4;
  localparam int FLAG_CAP = 3;
  localparam int FLAG_MB = 2;
  localparam int FLAG_MA = 1;
  localparam int FLAG_WRAP = 0;
  localparam int LVL_B_BIT = 3;
  localparam int LVL_A_BIT = 2;
  localparam int EDGE_SEL_BIT = 1;
  localparam int CLR_A_BIT = 0;

  // ==========================================================================
  // Count source codes and prescaler masks.
  localparam logic [1:0] SRC_DIV2 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [4:0] MASK_DIV2 = 5'h01;
  localparam logic [4:0] MASK_DIV8 = 5'h07;
  localparam logic [4:0] MASK_DIV32 = 5'h1F;

  typedef struct packed {
    logic capture_irq_en;
    logic match_irq_en_b;
    logic match_irq_en_a;
    logic wrap_irq_en;
    logic pin_drive_en_b;
    logic pin_drive_en_a;
    logic [1:0] count_source_sel;
  } cct_ctrl_type;

  typedef struct packed {
    logic capture_irq;
    logic match_irq_b;
    logic match_irq_a;
    logic wrap_irq;
  } cct_irq_type;

endpackage

// ### cct_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Produces one-cycle count pulses from the selected source.
module cct_tick_gen #(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic standby_i,
  // Source selection
  input wire logic [1:0] source_sel_i,
  input wire logic ext_count_clk_i,
  // Count pulse
  output logic tick_o
);

  if (DIV_W < 5) begin : g_div_check
    $error("cct_tick_gen: DIV_W must be at least 5");
  end

  logic [DIV_W-1:0] div_reg;
  logic ext_prev_reg;
  logic [4:0] mask;

  // ==========================================================================
  // Prescaler runs freely so that a source change takes effect at once.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
    end else if (standby_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_count_clk_i;
    end
  end

  always_comb begin
    case (source_sel_i)
      cct_pkg::SRC_DIV2: mask = cct_pkg::MASK_DIV2;
      cct_pkg::SRC_DIV8: mask = cct_pkg::MASK_DIV8;
      cct_pkg::SRC_DIV32: mask = cct_pkg::MASK_DIV32;
      default: mask = cct_pkg::MASK_DIV32;
    endcase
  end

  // External pulses count on the rising edge only.
  assign tick_o = standby_i ? 1'b0 :
                  (source_sel_i == cct_pkg::SRC_EXT) ? (ext_count_clk_i & ~ext_prev_reg) :
                  ((div_reg[4:0] & mask) == mask);

endmodule // cct_tick_gen

`default_nettype wire

// ### cct_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cct_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic standby_i,
  // CPU byte bus
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Timer pins
  input wire logic count_clk_i,
  input wire logic capture_pin_i,
  output logic compare_pin_a_o,
  output logic compare_pin_b_o,
  // Interrupt requests
  output cct_pkg::cct_irq_type irq_o
);

  // ==========================================================================
  // Reset release through two flip-flops.
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ==========================================================================
  // State.
  cct_pkg::cct_ctrl_type ctrl_reg;
  logic [3:0] flags_reg;
  logic [3:0] flag_seen_reg;
  logic [3:0] lvl_reg;
  logic [15:0] count_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] cap_reg;
  logic [7:0] temp_reg;
  logic [7:0] rdata_reg;
  logic fresh_reg;
  logic cap_prev_reg;
  logic pin_a_reg;
  logic pin_b_reg;

  logic tick;
  logic hit_a;
  logic hit_b;
  logic cap_edge;
  logic wrap_evt;
  logic cnt_clear;
  logic cnt_wr;
  logic flags_wr;
  logic [3:0] flag_set;

  function automatic logic bus_hit(input logic [15:0] a, input logic [15:0] target);
    bus_hit = (a == target);
  endfunction

  // A match counts once per new count value, not while the count sits still.
  function automatic logic cmp_hit(input logic fresh, input logic [15:0] cnt,
                                   input logic [15:0] cmp);
    cmp_hit = fresh & (cnt == cmp);
  endfunction

  cct_tick_gen #(
    .DIV_W(5)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .standby_i(standby_i),
    .source_sel_i(ctrl_reg.count_source_sel),
    .ext_count_clk_i(count_clk_i),
    .tick_o(tick)
  );

  assign hit_a = cmp_hit(fresh_reg, count_reg, cmp_a_reg);
  assign hit_b = cmp_hit(fresh_reg, count_reg, cmp_b_reg);
  assign cnt_wr = wr_i & bus_hit(addr_i, cct_pkg::ADDR_CNT_LO);
  assign cnt_clear = hit_a & lvl_reg[cct_pkg::CLR_A_BIT];
  assign wrap_evt = tick & (count_reg == cct_pkg::CNT_MAX) & ~cnt_wr & ~cnt_clear;
  assign flags_wr = wr_i & bus_hit(addr_i, cct_pkg::ADDR_FLAGS);
  // A 0 edge select picks the falling edge, 1 the rising edge.
  assign cap_edge = lvl_reg[cct_pkg::EDGE_SEL_BIT] ? (capture_pin_i & ~cap_prev_reg)
                                                   : (~capture_pin_i & cap_prev_reg);
  assign flag_set = {cap_edge, hit_b, hit_a, wrap_evt};

  // ==========================================================================
  // Control register.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= cct_pkg::CTRL_RESET;
    end else if (standby_i) begin
      ctrl_reg <= cct_pkg::CTRL_RESET;
    end else if (wr_i && bus_hit(addr_i, cct_pkg::ADDR_CTRL)) begin
      ctrl_reg <= wdata_i;
    end
  end

  // ==========================================================================
  // Level, edge and clear bits are plain read/write.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvl_reg <= cct_pkg::FLAGS_RESET[3:0];
    end else if (standby_i) begin
      lvl_reg <= cct_pkg::FLAGS_RESET[3:0];
    end else if (flags_wr) begin
      lvl_reg <= wdata_i[3:0];
    end
  end

  // ==========================================================================
  // Flags. A flag read as 1 arms its clear; a later 0 write clears it.
  // A hardware set in the clearing cycle wins, so no event is lost.
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        flags_reg[i] <= 1'b0;
        flag_seen_reg[i] <= 1'b0;
      end else if (standby_i) begin
        flags_reg[i] <= 1'b0;
        flag_seen_reg[i] <= 1'b0;
      end else begin
        if (flag_set[i]) begin
          flags_reg[i] <= 1'b1;
        end else if (flags_wr && flag_seen_reg[i] && !wdata_i[cct_pkg::FLAG_BASE + i]) begin
          flags_reg[i] <= 1'b0;
        end
        if (flags_wr) begin
          flag_seen_reg[i] <= 1'b0;
        end else if (rd_i && bus_hit(addr_i, cct_pkg::ADDR_FLAGS) && flags_reg[i]) begin
          flag_seen_reg[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Free-running count.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= cct_pkg::CNT_RESET;
      fresh_reg <= 1'b0;
    end else if (standby_i) begin
      count_reg <= cct_pkg::CNT_RESET;
      fresh_reg <= 1'b0;
    end else begin
      fresh_reg <= cnt_wr | cnt_clear | tick;
      if (cnt_wr) begin
        count_reg <= {temp_reg, wdata_i};
      end else if (cnt_clear) begin
        count_reg <= cct_pkg::CNT_RESET;
      end else if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Compare registers commit both bytes at the low-byte write.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_reg <= cct_pkg::CMP_RESET;
      cmp_b_reg <= cct_pkg::CMP_RESET;
    end else if (standby_i) begin
      cmp_a_reg <= cct_pkg::CMP_RESET;
      cmp_b_reg <= cct_pkg::CMP_RESET;
    end else if (wr_i && bus_hit(addr_i, cct_pkg::ADDR_CMPA_LO)) begin
      cmp_a_reg <= {temp_reg, wdata_i};
    end else if (wr_i && bus_hit(addr_i, cct_pkg::ADDR_CMPB_LO)) begin
      cmp_b_reg <= {temp_reg, wdata_i};
    end
  end

  // ==========================================================================
  // Capture. The pin is sampled each clock; a pulse shorter than about
  // one clock may fall between samples and be missed.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_prev_reg <= 1'b0;
    end else begin
      cap_prev_reg <= capture_pin_i;
    end
  end

  // Bus writes never reach this register.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg <= cct_pkg::CAP_RESET;
    end else if (standby_i) begin
      cap_reg <= cct_pkg::CAP_RESET;
    end else if (cap_edge) begin
      cap_reg <= count_reg;
    end
  end

  // ==========================================================================
  // Shared byte latch: count and compare high-byte writes fill it, high-byte reads of the
  // count or capture value park the low byte so both come from one sample.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= cct_pkg::TEMP_RESET;
    end else if (standby_i) begin
      temp_reg <= cct_pkg::TEMP_RESET;
    end else if (wr_i) begin
      if (bus_hit(addr_i, cct_pkg::ADDR_CNT_HI) || bus_hit(addr_i, cct_pkg::ADDR_CMPA_HI) ||
          bus_hit(addr_i, cct_pkg::ADDR_CMPB_HI)) begin
        temp_reg <= wdata_i;
      end
    end else if (rd_i) begin
      if (bus_hit(addr_i, cct_pkg::ADDR_CNT_HI)) begin
        temp_reg <= count_reg[7:0];
      end else if (bus_hit(addr_i, cct_pkg::ADDR_CAP_HI)) begin
        temp_reg <= cap_reg[7:0];
      end
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe. Unmapped addresses read zero.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        cct_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
        cct_pkg::ADDR_FLAGS: rdata_reg <= {flags_reg, lvl_reg};
        cct_pkg::ADDR_CNT_HI: rdata_reg <= count_reg[15:8];
        cct_pkg::ADDR_CNT_LO: rdata_reg <= temp_reg;
        cct_pkg::ADDR_CMPA_HI: rdata_reg <= cmp_a_reg[15:8];
        cct_pkg::ADDR_CMPA_LO: rdata_reg <= cmp_a_reg[7:0];
        cct_pkg::ADDR_CMPB_HI: rdata_reg <= cmp_b_reg[15:8];
        cct_pkg::ADDR_CMPB_LO: rdata_reg <= cmp_b_reg[7:0];
        cct_pkg::ADDR_CAP_HI: rdata_reg <= cap_reg[15:8];
        cct_pkg::ADDR_CAP_LO: rdata_reg <= temp_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign rdata_o = rdata_reg;

  // ==========================================================================
  // Compare pins hold their level until an enabled match.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else if (standby_i) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else begin
      if (hit_a && ctrl_reg.pin_drive_en_a) begin
        pin_a_reg <= lvl_reg[cct_pkg::LVL_A_BIT];
      end
      if (hit_b && ctrl_reg.pin_drive_en_b) begin
        pin_b_reg <= lvl_reg[cct_pkg::LVL_B_BIT];
      end
    end
  end
  assign compare_pin_a_o = pin_a_reg;
  assign compare_pin_b_o = pin_b_reg;

  // ==========================================================================
  // Interrupt requests are levels.
  assign irq_o.capture_irq = flags_reg[cct_pkg::FLAG_CAP] & ctrl_reg.capture_irq_en;
  assign irq_o.match_irq_b = flags_reg[cct_pkg::FLAG_MB] & ctrl_reg.match_irq_en_b;
  assign irq_o.match_irq_a = flags_reg[cct_pkg::FLAG_MA] & ctrl_reg.match_irq_en_a;
  assign irq_o.wrap_irq = flags_reg[cct_pkg::FLAG_WRAP] & ctrl_reg.wrap_irq_en;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_read_flag_a;
    rd_i && bus_hit(addr_i, cct_pkg::ADDR_FLAGS) && flags_reg[cct_pkg::FLAG_MA] && !standby_i;
  endsequence
  sequence s_write_zero_a;
    flags_wr && !wdata_i[cct_pkg::FLAG_BASE + cct_pkg::FLAG_MA] && !hit_a && !standby_i;
  endsequence

  a_flag_clear_seq: assert property (s_read_flag_a ##1 s_write_zero_a |=> !flags_reg[1])
    else $error("match flag A not cleared after read then zero write");
  a_match_flag: assert property (hit_a && !standby_i |=> flags_reg[1] && irq_o.match_irq_a == ctrl_reg.match_irq_en_a)
    else $error("compare A match did not set its flag");
  a_pin_drive: assert property (hit_b && ctrl_reg.pin_drive_en_b && !standby_i |=> compare_pin_b_o == $past(lvl_reg[3]))
    else $error("compare pin B not driven to level on match");
  a_pin_hold: assert property (!(hit_a && ctrl_reg.pin_drive_en_a) && !standby_i |=> $stable(compare_pin_a_o))
    else $error("compare pin A changed without enabled match");
  a_cmp_standby: assert property (standby_i |=> cmp_a_reg == 16'hFFFF && cmp_b_reg == 16'hFFFF)
    else $error("compare registers not all ones after standby");
  a_cmp_latch: assert property (wr_i && addr_i == 16'hFF94 && !standby_i ##1 wr_i && addr_i == 16'hFF95 && !standby_i |=> cmp_a_reg == {$past(wdata_i, 2), $past(wdata_i)})
    else $error("compare A did not commit both bytes together");
  a_cap_copy: assert property (cap_edge && !standby_i |=> cap_reg == $past(count_reg) && flags_reg[3])
    else $error("capture did not copy count and set flag");
  a_cap_readonly: assert property (!cap_edge && !standby_i |=> $stable(cap_reg))
    else $error("capture register changed without capture edge");
  a_cap_standby: assert property (standby_i |=> cap_reg == 16'h0000 && ctrl_reg == 8'h00)
    else $error("capture or control not cleared by standby");
  a_wrap_set: assert property (tick && count_reg == 16'hFFFF && !cnt_wr && !cnt_clear && !standby_i |=> count_reg == 16'h0000 && flags_reg[0])
    else $error("rollover did not set wrap flag");
  a_clear_on_a: assert property (hit_a && lvl_reg[0] && !cnt_wr && !standby_i |=> count_reg == 16'h0000)
    else $error("count not cleared on compare A match");

endmodule // cct_timer

`default_nettype wire

// ### cct_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Far side of the timer pins: capture source, external count clock and loads.
module cct_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Driven pins
  output logic capture_pin_o,
  output logic count_clk_o,
  // Waveform loads
  input wire logic compare_pin_a_i,
  input wire logic compare_pin_b_i
);
  initial begin
    capture_pin_o = 1'b0;
    count_clk_o = 1'b0;
  end

  // Each level is held two cycles, so no pulse is shorter than the minimum width.
  task automatic set_capture(input logic level);
    capture_pin_o = level;
    repeat (2) @(negedge sys_clk_i);
  endtask

  // The count clock stands still outside a burst of pulses.
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      count_clk_o = ~count_clk_o;
      repeat (2) @(negedge sys_clk_i);
      count_clk_o = ~count_clk_o;
      repeat (2) @(negedge sys_clk_i);
    end
  endtask
endmodule // cct_far_model

`default_nettype wire

// ### compare_capture_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Register-level bench for the compare and capture timer.
module compare_capture_timer_bench;
  logic sys_clk_i, rst_n_i, standby_i, wr_i, rd_i;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, f;
  logic count_clk_i, capture_pin_i, compare_pin_a_o, compare_pin_b_o;
  cct_pkg::cct_irq_type irq_o;
  logic [15:0] v, c1, c2;
  int errors = 0;
  int total_checks = 0;

  cct_timer cct_timer_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .count_clk_i(count_clk_i), .capture_pin_i(capture_pin_i),
    .compare_pin_a_o(compare_pin_a_o), .compare_pin_b_o(compare_pin_b_o), .irq_o(irq_o));

  cct_far_model cct_far_model_i (.sys_clk_i(sys_clk_i), .capture_pin_o(capture_pin_i),
    .count_clk_o(count_clk_i), .compare_pin_a_i(compare_pin_a_o),
    .compare_pin_b_i(compare_pin_b_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Reporting.
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ==========================================================================
  // Byte bus cycles; every task starts and ends just after a falling edge.
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr_i = w;
    rd_i = r;
    addr_i = a;
    wdata_i = d;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic idle;
    wr_i = 1'b0;
    rd_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    idle();
  endtask

  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    d = rdata_o;
    idle();
  endtask

  // The high byte always goes first so the shared latch pairs the two halves.
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d[15:8]);
    bus(1'b1, 1'b0, a + 16'h0001, d[7:0]);
    idle();
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    d[15:8] = rdata_o;
    bus(1'b0, 1'b1, a + 16'h0001, 8'h00);
    d[7:0] = rdata_o;
    idle();
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = compare_pin_a_o;
      1: pick = irq_o.wrap_irq;
      default: pick = irq_o.match_irq_a;
    endcase
  endfunction

  task automatic wait_sig(input int sel, input logic level);
    int n;
    n = 0;
    while (pick(sel) !== level && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      test_done();
    end
  endtask

  task automatic chk_quiet(input string what);
    check(16'({compare_pin_a_o, compare_pin_b_o, irq_o}), 16'h0000, what);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    standby_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    rd8(cct_pkg::ADDR_CTRL, f);
    check(16'(f), 16'h0000, "ctrl reset");
    rd16(cct_pkg::ADDR_CMPA_HI, v);
    check(v, 16'hFFFF, "cmp a reset");
    rd16(cct_pkg::ADDR_CMPB_HI, v);
    check(v, 16'hFFFF, "cmp b reset");
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h0000, "cap reset");
    chk_quiet("pins irq reset");
    wr8(cct_pkg::ADDR_CTRL, 8'hA5);
    rd8(cct_pkg::ADDR_CTRL, f);
    check(16'(f), 16'h00A5, "ctrl rw");
    wr8(cct_pkg::ADDR_CTRL, 8'h00);
    wr8(cct_pkg::ADDR_CAP_HI, 8'h55);
    wr8(cct_pkg::ADDR_CAP_LO, 8'hAA);
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h0000, "cap write ignored");
    rd8(16'hFF9A, f);
    check(16'(f), 16'h0000, "unmapped read");
    wr8(cct_pkg::ADDR_CMPA_HI, 8'h01);
    rd8(cct_pkg::ADDR_CMPA_HI, f);
    check(16'(f), 16'h00FF, "half write held back");
    wr8(cct_pkg::ADDR_CMPA_LO, 8'h10);
    rd16(cct_pkg::ADDR_CMPA_HI, v);
    check(v, 16'h0110, "cmp a commit");
    wr16(cct_pkg::ADDR_CMPB_HI, 16'h0118);
    // Both matches driven from one count run; only pin A has drive enabled.
    wr8(cct_pkg::ADDR_FLAGS, 8'h0C);
    wr8(cct_pkg::ADDR_CTRL, 8'h24);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h0100);
    wait_sig(0, 1'b1);
    check(16'(irq_o.match_irq_a), 16'h0001, "irq a");
    repeat (60) @(negedge sys_clk_i);
    check(16'(compare_pin_a_o), 16'h0001, "pin a holds");
    check(16'(compare_pin_b_o), 16'h0000, "pin b undriven");
    check(16'(irq_o.match_irq_b), 16'h0000, "irq b masked");
    rd8(cct_pkg::ADDR_FLAGS, f);
    check(16'(f), 16'h006C, "match flags");
    wr8(cct_pkg::ADDR_CTRL, 8'h64);
    check(16'(irq_o.match_irq_b), 16'h0001, "irq b");
    wr8(cct_pkg::ADDR_CTRL, 8'h24);
    check(16'(irq_o.match_irq_b), 16'h0000, "irq b drop");
    wr8(cct_pkg::ADDR_FLAGS, 8'h0C);
    rd8(cct_pkg::ADDR_FLAGS, f);
    check(16'(f), 16'h000C, "flags cleared");
    check(16'(irq_o.match_irq_a), 16'h0000, "irq a drop");
    wr8(cct_pkg::ADDR_FLAGS, 8'hFC);
    rd8(cct_pkg::ADDR_FLAGS, f);
    check(16'(f), 16'h000C, "flags not set by write");
    wr8(cct_pkg::ADDR_FLAGS, 8'h00);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h0108);
    wait_sig(0, 1'b0);
    // Read and zero write back to back, so the armed clear is exercised at full speed.
    bus(1'b0, 1'b1, cct_pkg::ADDR_FLAGS, 8'h00);
    f = rdata_o;
    check(16'(f[5]), 16'h0001, "flag a set again");
    wr8(cct_pkg::ADDR_FLAGS, 8'h01);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h0100);
    wait_sig(2, 1'b1);
    repeat (10) @(negedge sys_clk_i);
    rd16(cct_pkg::ADDR_CNT_HI, v);
    check(16'(v[15:8]), 16'h0000, "clear on match a");
    wr8(cct_pkg::ADDR_FLAGS, 8'h00);
    wr8(cct_pkg::ADDR_CTRL, 8'h10);
    wr16(cct_pkg::ADDR_CNT_HI, 16'hFFF0);
    wait_sig(1, 1'b1);
    rd8(cct_pkg::ADDR_FLAGS, f);
    check(16'(f[4]), 16'h0001, "wrap flag");
    // Snapshots 320 cycles apart; the prescaler phase allows one count of slack.
    for (int i = 0; i < 3; i++) begin
      wr8(cct_pkg::ADDR_CTRL, 8'(i));
      rd16(cct_pkg::ADDR_CNT_HI, c1);
      repeat (317) @(negedge sys_clk_i);
      rd16(cct_pkg::ADDR_CNT_HI, c2);
      v = c2 - c1;
      check(16'(v >= (16'd160 >> (2 * i)) - 1 && v <= (16'd160 >> (2 * i)) + 1),
        16'h0001, "count rate");
    end
    wr8(cct_pkg::ADDR_CTRL, 8'h83);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h1234);
    cct_far_model_i.ext_pulses(5);
    rd16(cct_pkg::ADDR_CNT_HI, v);
    check(v, 16'h1239, "external count");
    wr8(cct_pkg::ADDR_FLAGS, 8'h02);
    cct_far_model_i.set_capture(1'b1);
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h1239, "capture rising");
    check(16'(irq_o.capture_irq), 16'h0001, "irq capture");
    cct_far_model_i.set_capture(1'b0);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h5678);
    cct_far_model_i.set_capture(1'b1);
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h5678, "capture overwrite");
    wr8(cct_pkg::ADDR_FLAGS, 8'h00);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h9ABC);
    cct_far_model_i.set_capture(1'b0);
    wr16(cct_pkg::ADDR_CNT_HI, 16'h0DEF);
    cct_far_model_i.set_capture(1'b1);
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h9ABC, "capture falling only");
    rd8(cct_pkg::ADDR_FLAGS, f);
    check(16'(f[7]), 16'h0001, "unread flag kept");
    wr8(cct_pkg::ADDR_FLAGS, 8'h00);
    check(16'(irq_o.capture_irq), 16'h0000, "irq capture drop");
    wr8(cct_pkg::ADDR_CTRL, 8'h24);
    standby_i = 1'b1;
    @(negedge sys_clk_i);
    standby_i = 1'b0;
    @(negedge sys_clk_i);
    rd8(cct_pkg::ADDR_CTRL, f);
    check(16'(f), 16'h0000, "ctrl standby");
    rd16(cct_pkg::ADDR_CMPA_HI, v);
    check(v, 16'hFFFF, "cmp standby");
    rd16(cct_pkg::ADDR_CAP_HI, v);
    check(v, 16'h0000, "cap standby");
    chk_quiet("pins irq standby");
    wr16(cct_pkg::ADDR_CMPA_HI, 16'h2345);
    rd16(cct_pkg::ADDR_CMPA_HI, v);
    check(v, 16'h2345, "cmp a wide write");
    test_done();
  end
endmodule // compare_capture_timer_bench

`default_nettype wire
